// File: essc_pkg.sv
// ****************************************************************************
// Shared constants for the enable, sleep and wake control block.
// ****************************************************************************
package essc_pkg;

	// Clock period in picoseconds (10 MHz clock).
	localparam int unsigned CLK_PERIOD_PS   = 100000;

	// Time that enable must stay low before standby or sleep, in microseconds.
	localparam int unsigned STANDBY_LOW_US  = 1000;
	// Least low time on enable or translator one input before a wake edge, in microseconds.
	localparam int unsigned WAKE_LOW_US     = 250;
	// Least dominant time on the bus before a wake edge, in microseconds.
	localparam int unsigned BUS_DOM_US      = 150;
	// Longest delay from enable low to gates low, in nanoseconds.
	localparam int unsigned GATE_OFF_NS     = 100;

	// Cycle counts derived from the times above; least times round up.
	localparam int unsigned STANDBY_LOW_CYC =
		(STANDBY_LOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WAKE_LOW_CYC    =
		(WAKE_LOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned BUS_DOM_CYC     =
		(BUS_DOM_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Longest time rounds down, but never below one cycle.
	localparam int unsigned GATE_OFF_CYC    =
		(GATE_OFF_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 : (GATE_OFF_NS * 1000 / CLK_PERIOD_PS);

	// Width of the duration counters.
	localparam int unsigned CNT_W           = 16;

	// Reset values of the fault and bus pull-up outputs.
	localparam logic        RST_FAULT       = 1'b0;
	localparam logic        RST_PULLUP      = 1'b1;

	// Operating modes.
	typedef enum logic [1:0] {
		ESSC_NORMAL,
		ESSC_STANDBY,
		ESSC_SLEEP
	} essc_mode_t;

endpackage : essc_pkg

// File: essc_low_timer.sv
`timescale 1ns/10ps
// ****************************************************************************
// Qualified low detector: synchronises a level, counts how long it has been
// low, and flags a rising edge that follows a long enough low.
// ****************************************************************************
module essc_low_timer #(
	parameter int unsigned LIMIT = 2500
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic async_in,
	output logic      level,
	output logic      low_met,
	output logic      rise_after_low
);

	logic                          meta_ff;   // First synchroniser stage.
	logic                          sync_ff;   // Second synchroniser stage.
	logic                          prev_ff;   // Delayed copy for edge detection.
	logic [essc_pkg::CNT_W-1:0]    cnt_ff;    // Cycles spent low so far.
	logic                          met_ff;    // The low lasted at least LIMIT.
	logic                          rise_ff;   // Registered qualified rising edge.
	wire                           rise_w;    // Plain rising edge of the input.
	wire  [essc_pkg::CNT_W-1:0]    nxt_cnt;   // Saturating next count.
	localparam logic [essc_pkg::CNT_W-1:0] LIM_W = essc_pkg::CNT_W'(LIMIT);

	assign rise_w  = sync_ff & ~prev_ff;
	assign nxt_cnt = sync_ff ? '0 : ((cnt_ff == LIM_W) ? cnt_ff : cnt_ff + 1'b1);

	// ************************************************************************
	// Synchronise, count and detect.
	// ************************************************************************
	// The count saturates at the limit so a long low never wraps.
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
			cnt_ff  <= '0;
			met_ff  <= 1'b0;
			rise_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
			cnt_ff  <= nxt_cnt;
			met_ff  <= ~sync_ff & (nxt_cnt >= LIM_W);
			rise_ff <= rise_w & (cnt_ff >= LIM_W);
		end
	end

	assign level          = sync_ff;
	assign low_met        = met_ff;
	assign rise_after_low = rise_ff;

endmodule : essc_low_timer

// File: essc_ctrl.sv
`timescale 1ns/10ps
module essc_ctrl #(
	parameter bit          HAS_TRANSLATORS = 1'b1,
	parameter int unsigned DEADTIME_W      = 4,
	parameter int unsigned STANDBY_CYC     = essc_pkg::STANDBY_LOW_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  chip_enable,
	input  wire logic                  sleep_select,
	input  wire logic                  input_pullup_enable,
	input  wire logic                  bus_pullup_cfg,
	input  wire logic [DEADTIME_W-1:0] deadtime_config_reg,
	input  wire logic                  driver_fault_active,
	input  wire logic                  phase_a_high_cmd,
	input  wire logic                  phase_a_low_cmd,
	input  wire logic                  phase_b_high_cmd,
	input  wire logic                  phase_b_low_cmd,
	input  wire logic                  phase_c_high_cmd,
	input  wire logic                  phase_c_low_cmd,
	input  wire logic                  translator_one_input,
	input  wire logic                  translator_two_input,
	input  wire logic                  bus_in,
	output logic                       phase_a_high_gate,
	output logic                       phase_a_low_gate,
	output logic                       phase_b_high_gate,
	output logic                       phase_b_low_gate,
	output logic                       phase_c_high_gate,
	output logic                       phase_c_low_gate,
	output logic                       translator_one_output_oe,
	output logic                       translator_two_output_oe,
	output logic                       current_limit_fault_output_oe,
	output logic                       amp_enable,
	output logic                       reg12_enable,
	output logic                       reg5_enable,
	output logic                       input_pullup_on,
	output logic                       bus_pullup_on,
	output logic                       fault_latched,
	output logic [1:0]                 mode
);

	// ************************************************************************
	// Declarations.
	// ************************************************************************
	essc_pkg::essc_mode_t  mode_ff;          // Current operating mode.
	essc_pkg::essc_mode_t  nxt_mode;         // Next operating mode.
	logic [5:0]            gate_ff;          // Gate outputs, high then low per phase.
	logic [5:0]            nxt_gate;         // Gate next values.
	logic [5:0]            last_ff;          // Last gate state seen, for dead time.
	logic [5:0]            dt_ok;            // Per-gate dead time satisfied.
	logic [DEADTIME_W-1:0] dt_cnt_ff [3];    // Per-phase dead time counters.
	logic                  en_q_ff;          // Enable registered directly for fast off.
	logic                  en_prev_ff;       // Previous synchronised enable.
	logic                  fault_ff;         // Latched driver fault.
	logic                  tr1_ff;           // Translator one pulldown enable.
	logic                  tr2_ff;           // Translator two pulldown enable.
	logic                  ilim_ff;          // Fault pin pulldown enable.
	logic                  pu_in_ff;         // Sampled input pull-up enable.
	logic                  bus_pu_ff;        // Bus pull-up state.
	logic                  amp_ff;           // Amplifier enable.
	logic                  r12_ff;           // Twelve volt regulator enable.
	logic                  r5_ff;            // Five volt regulator enable.
	wire                   en_lvl;           // Synchronised enable level.
	wire                   en_long;          // Enable low long enough for standby.
	wire                   en_wake;          // Qualified enable wake edge.
	wire                   tr1_wake;         // Qualified translator one wake edge.
	wire                   bus_wake;         // Qualified bus wake edge.
	wire                   en_rise;          // Rising edge of enable.
	wire                   wake;             // Enable wake, or translator one wake (bus wake without translators).
	wire                   normal_w;         // Mode is normal.
	wire [5:0]             cmd;              // Raw phase commands.

	// ************************************************************************
	// Input qualification timers.
	// ************************************************************************
	// Enable: counts the long low that leads to standby or sleep.
	essc_low_timer #(.LIMIT(STANDBY_CYC)) u_en_standby (
		.clk            (clk),
		.srst           (srst),
		.async_in       (chip_enable),
		.level          (en_lvl),
		.low_met        (en_long),
		.rise_after_low ()
	);

	// Enable: wake edge after a qualified low.
	essc_low_timer #(.LIMIT(essc_pkg::WAKE_LOW_CYC)) u_en_wake (
		.clk            (clk),
		.srst           (srst),
		.async_in       (chip_enable),
		.level          (),
		.low_met        (),
		.rise_after_low (en_wake)
	);

	// Translator one input wake timer.
	essc_low_timer #(.LIMIT(essc_pkg::WAKE_LOW_CYC)) u_tr1_wake (
		.clk            (clk),
		.srst           (srst),
		.async_in       (translator_one_input),
		.level          (),
		.low_met        (),
		.rise_after_low (tr1_wake)
	);

	// Bus wake timer; a dominant bus reads low.
	essc_low_timer #(.LIMIT(essc_pkg::BUS_DOM_CYC)) u_bus_wake (
		.clk            (clk),
		.srst           (srst),
		.async_in       (bus_in),
		.level          (),
		.low_met        (),
		.rise_after_low (bus_wake)
	);

	// ************************************************************************
	// Mode decode.
	// ************************************************************************
	assign en_rise  = en_lvl & ~en_prev_ff;
	assign normal_w = (mode_ff == essc_pkg::ESSC_NORMAL);
	assign wake     = en_wake | (HAS_TRANSLATORS ? tr1_wake : bus_wake);
	assign cmd      = {phase_a_high_cmd, phase_a_low_cmd, phase_b_high_cmd,
		phase_b_low_cmd, phase_c_high_cmd, phase_c_low_cmd};

	// Mode selection: a long low leaves normal, a short pulse does not.
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			essc_pkg::ESSC_NORMAL: begin
				if (en_long) begin
					nxt_mode = sleep_select ? essc_pkg::ESSC_SLEEP : essc_pkg::ESSC_STANDBY;
				end
			end
			essc_pkg::ESSC_STANDBY: begin
				if (en_lvl) begin
					nxt_mode = essc_pkg::ESSC_NORMAL;
				end
			end
			essc_pkg::ESSC_SLEEP: begin
				if (wake) begin
					nxt_mode = en_lvl ? essc_pkg::ESSC_NORMAL : essc_pkg::ESSC_STANDBY;
				end
			end
			default: begin
				nxt_mode = essc_pkg::ESSC_NORMAL;
			end
		endcase
	end

	// ************************************************************************
	// Gate drive with optional dead time.
	// ************************************************************************
	// A gate turns on only after its phase partner has been off for the
	// configured number of cycles; zero leaves dead time to the host.
	// The partner's present state is looked at as well, because the record
	// of the last gate on is one cycle behind the gates themselves.
	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_phase
			assign dt_ok[2*p+1] = (deadtime_config_reg == '0) |
				(~gate_ff[2*p] & ((dt_cnt_ff[p] == '0) | ~last_ff[2*p]));
			assign dt_ok[2*p]   = (deadtime_config_reg == '0) |
				(~gate_ff[2*p+1] & ((dt_cnt_ff[p] == '0) | ~last_ff[2*p+1]));
			// Counter reloads one short of the setting whenever either gate of
			// the phase is on, so the gap that follows lasts the set cycles.
			always_ff @(posedge clk) begin
				if (srst | (|gate_ff[2*p+1:2*p])) begin
					dt_cnt_ff[p] <= deadtime_config_reg - 1'b1;
				end else if (dt_cnt_ff[p] != '0) begin
					dt_cnt_ff[p] <= dt_cnt_ff[p] - 1'b1;
				end
			end
		end
	endgenerate

	// Commands pass only while enable is high; both gates of a phase never on.
	assign nxt_gate = (en_q_ff & normal_w) ? (cmd & dt_ok & ~{cmd[4], cmd[5], cmd[2],
		cmd[3], cmd[0], cmd[1]}) : 6'h00;

	// ************************************************************************
	// Main registers.
	// ************************************************************************
	// Enable is registered once for gate-off so one 100 ns cycle suffices.
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_ff    <= essc_pkg::ESSC_NORMAL;
			en_q_ff    <= 1'b0;
			en_prev_ff <= 1'b0;
			gate_ff    <= 6'h00;
			last_ff    <= 6'h00;
		end else begin
			mode_ff    <= nxt_mode;
			en_q_ff    <= chip_enable;
			en_prev_ff <= en_lvl;
			gate_ff    <= chip_enable ? nxt_gate : 6'h00;
			last_ff    <= gate_ff | (last_ff & ~{gate_ff[4], gate_ff[5], gate_ff[2],
				gate_ff[3], gate_ff[0], gate_ff[1]});
		end
	end

	// Fault latch: a new fault wins over the clear on the enable edge.
	always_ff @(posedge clk) begin
		if (srst) begin
			fault_ff <= essc_pkg::RST_FAULT;
		end else if (driver_fault_active) begin
			fault_ff <= 1'b1;
		end else if (en_rise) begin
			fault_ff <= 1'b0;
		end
	end

	// Supplies, pull-ups, translators and fault pin.
	always_ff @(posedge clk) begin
		if (srst) begin
			amp_ff    <= 1'b1;
			r12_ff    <= 1'b1;
			r5_ff     <= 1'b1;
			pu_in_ff  <= 1'b0;
			bus_pu_ff <= essc_pkg::RST_PULLUP;
			tr1_ff    <= 1'b0;
			tr2_ff    <= 1'b0;
			ilim_ff   <= 1'b0;
		end else begin
			amp_ff   <= (nxt_mode == essc_pkg::ESSC_NORMAL);
			r12_ff   <= (nxt_mode == essc_pkg::ESSC_NORMAL);
			r5_ff    <= ~HAS_TRANSLATORS | (nxt_mode == essc_pkg::ESSC_NORMAL);
			// The pin itself gates sampling, so a change made as enable rises
			// is not picked up during the synchroniser delay.
			if (~chip_enable) begin
				pu_in_ff <= input_pullup_enable;
			end
			case (nxt_mode)
				essc_pkg::ESSC_NORMAL:  bus_pu_ff <= 1'b1;
				essc_pkg::ESSC_SLEEP:   bus_pu_ff <= 1'b0;
				default:                bus_pu_ff <= bus_pullup_cfg;
			endcase
			tr1_ff   <= ~translator_one_input;
			tr2_ff   <= ~translator_two_input;
			ilim_ff  <= fault_ff | driver_fault_active;
		end
	end

	// ************************************************************************
	// Outputs.
	// ************************************************************************
	assign phase_a_high_gate             = gate_ff[5];
	assign phase_a_low_gate              = gate_ff[4];
	assign phase_b_high_gate             = gate_ff[3];
	assign phase_b_low_gate              = gate_ff[2];
	assign phase_c_high_gate             = gate_ff[1];
	assign phase_c_low_gate              = gate_ff[0];
	assign translator_one_output_oe      = tr1_ff;
	assign translator_two_output_oe      = tr2_ff;
	assign current_limit_fault_output_oe = ilim_ff;
	assign amp_enable                    = amp_ff;
	assign reg12_enable                  = r12_ff;
	assign reg5_enable                   = r5_ff;
	assign input_pullup_on               = pu_in_ff;
	assign bus_pullup_on                 = bus_pu_ff;
	assign fault_latched                 = fault_ff;
	assign mode                          = mode_ff;

endmodule : essc_ctrl

// File: essc_assertions.sv
`timescale 1ns/10ps
// ****************************************************************************
// Checker for the enable, sleep and wake control block.
// ****************************************************************************
module essc_assertions #(
	parameter int unsigned DEADTIME_W = 4
) (
	clk,
	srst,
	chip_enable,
	driver_fault_active,
	phase_a_high_cmd,
	phase_a_high_gate,
	phase_a_low_gate,
	phase_b_high_gate,
	phase_b_low_gate,
	phase_c_high_gate,
	phase_c_low_gate,
	translator_one_input,
	translator_one_output_oe,
	current_limit_fault_output_oe,
	input_pullup_on,
	amp_enable,
	reg12_enable,
	bus_pullup_on,
	fault_latched,
	mode,
	deadtime_config_reg
);
	input wire logic       clk, srst, chip_enable, driver_fault_active, phase_a_high_cmd;
	input wire logic       phase_a_high_gate, phase_a_low_gate, phase_b_high_gate;
	input wire logic       phase_b_low_gate, phase_c_high_gate, phase_c_low_gate;
	input wire logic       translator_one_input, translator_one_output_oe;
	input wire logic       current_limit_fault_output_oe, input_pullup_on, amp_enable;
	input wire logic       reg12_enable, bus_pullup_on, fault_latched;
	input wire logic [1:0] mode;
	input wire logic [DEADTIME_W-1:0] deadtime_config_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// All six gate outputs as one vector.
	wire logic [5:0] gates = {phase_a_high_gate, phase_a_low_gate, phase_b_high_gate,
		phase_b_low_gate, phase_c_high_gate, phase_c_low_gate};
	gates_off_a: assert property (!chip_enable |=> gates == 6'h00)
		else $error("gates stayed on after enable low");
	standby_wait_a: assert property ($fell(chip_enable) && mode == 2'h0 |=> (mode == 2'h0)[*8])
		else $error("mode left normal too early");
	shoot_guard_a: assert property (!(phase_a_high_gate && phase_a_low_gate))
		else $error("both phase a gates on");
	gate_cause_a: assert property ($rose(phase_a_high_gate) |-> $past(phase_a_high_cmd) || $past(phase_a_high_cmd, 2))
		else $error("gate rose without command");
	fault_set_a: assert property (driver_fault_active |=> fault_latched)
		else $error("fault not latched");
	fault_pin_a: assert property (fault_latched || driver_fault_active |=> current_limit_fault_output_oe)
		else $error("fault pin not pulled low");
	translate_a: assert property (!$past(srst) |-> translator_one_output_oe == !$past(translator_one_input))
		else $error("translator output wrong");
	pullup_hold_a: assert property ($past(chip_enable) |-> $stable(input_pullup_on))
		else $error("pull-up changed while enabled");
	dead_gap_a: assert property ($fell(phase_a_high_gate) && $past(deadtime_config_reg) != '0 |-> !phase_a_low_gate)
		else $error("low gate on with no dead time");
	bus_pull_a: assert property ((mode == 2'h0)[*2] |-> bus_pullup_on)
		else $error("bus pull-up off in normal");
	sleep_pull_a: assert property ((mode == 2'h2)[*2] |-> !bus_pullup_on)
		else $error("bus pull-up on in sleep");
	standby_off_a: assert property ((mode == 2'h1)[*2] |-> !amp_enable && !reg12_enable)
		else $error("amplifier or regulator on in standby");
	// Main scenarios reached.
	sleep_c: cover property (mode == 2'h2);
	standby_c: cover property (mode == 2'h1);
	clear_c: cover property ($fell(fault_latched));
	dead_c: cover property ($fell(phase_a_high_gate) && $past(deadtime_config_reg) != '0);
endmodule : essc_assertions

// File: essc_host_model.sv
`timescale 1ns/10ps
// ****************************************************************************
// Host controller model: drives enable, phase commands and the bus line.
// ****************************************************************************
module essc_host_model (
	input  wire logic clk,
	output logic       chip_enable,
	output logic [5:0] cmd,
	output logic       bus_in
);
	// Undriven pins read low; the bus idles recessive.
	initial begin
		chip_enable = 1'b0;
		cmd = 6'h00;
		bus_in = 1'b1;
	end
	// Moves the enable pin just after a falling edge.
	task drive_en(input logic v);
		@(negedge clk);
		chip_enable = v;
	endtask : drive_en
	// Short low pulses clear faults, long ones wake from sleep.
	task low_pulse(input int n);
		drive_en(1'b0);
		repeat (n) @(negedge clk);
		chip_enable = 1'b1;
	endtask : low_pulse
	// Holds the bus dominant for n cycles, then lets it go recessive.
	task bus_pulse(input int n);
		@(negedge clk);
		bus_in = 1'b0;
		repeat (n) @(negedge clk);
		bus_in = 1'b1;
	endtask : bus_pulse
	// Sets the six phase commands, high then low per phase.
	task set_cmd(input logic [5:0] c);
		@(negedge clk);
		cmd = c;
	endtask : set_cmd
endmodule : essc_host_model

// File: tb_top.sv
`timescale 1ns/10ps
// ****************************************************************************
// Testbench for the enable, sleep and wake control block.
// ****************************************************************************
module tb_top;
	logic       clk, srst, sleep_sel, pu_en, bus_cfg, fault_in, tr1, tr2, v;
	logic       chip_enable, bus_in, tr1_oe, tr2_oe, flt_oe, amp, r12, r5, pu_on, bus_pu, flt;
	logic [5:0] cmd, g;
	logic [1:0] mode, mode_b;
	logic [3:0] dt_cfg;
	logic       r5_b;
	int         n_errors = 0;
	int         check_count = 0;
	essc_host_model u_essc_host_model (.clk(clk), .chip_enable(chip_enable), .cmd(cmd),
		.bus_in(bus_in));
	essc_ctrl #(.STANDBY_CYC(20)) u_essc_ctrl (.clk(clk), .srst(srst),
		.chip_enable(chip_enable), .sleep_select(sleep_sel), .input_pullup_enable(pu_en),
		.bus_pullup_cfg(bus_cfg), .deadtime_config_reg(dt_cfg), .driver_fault_active(fault_in),
		.phase_a_high_cmd(cmd[5]), .phase_a_low_cmd(cmd[4]), .phase_b_high_cmd(cmd[3]),
		.phase_b_low_cmd(cmd[2]), .phase_c_high_cmd(cmd[1]), .phase_c_low_cmd(cmd[0]),
		.translator_one_input(tr1), .translator_two_input(tr2), .bus_in(bus_in),
		.phase_a_high_gate(g[5]), .phase_a_low_gate(g[4]), .phase_b_high_gate(g[3]),
		.phase_b_low_gate(g[2]), .phase_c_high_gate(g[1]), .phase_c_low_gate(g[0]),
		.translator_one_output_oe(tr1_oe), .translator_two_output_oe(tr2_oe),
		.current_limit_fault_output_oe(flt_oe), .amp_enable(amp), .reg12_enable(r12),
		.reg5_enable(r5), .input_pullup_on(pu_on), .bus_pullup_on(bus_pu),
		.fault_latched(flt), .mode(mode));
	// Bus variant: same inputs, wakes on the bus instead of translator one.
	essc_ctrl #(.HAS_TRANSLATORS(1'b0), .STANDBY_CYC(20)) u_essc_ctrl_bus (.clk(clk),
		.srst(srst), .chip_enable(chip_enable), .sleep_select(sleep_sel),
		.input_pullup_enable(pu_en), .bus_pullup_cfg(bus_cfg), .deadtime_config_reg(dt_cfg),
		.driver_fault_active(fault_in), .phase_a_high_cmd(cmd[5]), .phase_a_low_cmd(cmd[4]),
		.phase_b_high_cmd(cmd[3]), .phase_b_low_cmd(cmd[2]), .phase_c_high_cmd(cmd[1]),
		.phase_c_low_cmd(cmd[0]), .translator_one_input(tr1), .translator_two_input(tr2),
		.bus_in(bus_in), .phase_a_high_gate(), .phase_a_low_gate(), .phase_b_high_gate(),
		.phase_b_low_gate(), .phase_c_high_gate(), .phase_c_low_gate(),
		.translator_one_output_oe(), .translator_two_output_oe(),
		.current_limit_fault_output_oe(), .amp_enable(), .reg12_enable(), .reg5_enable(r5_b),
		.input_pullup_on(), .bus_pullup_on(), .fault_latched(), .mode(mode_b));
	// Free-running 10 MHz clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Expected gates: a phase with both commands high is held off.
	function automatic logic [5:0] exp_gates(input logic [5:0] c);
		for (int i = 0; i < 3; i++) begin
			if (c[2*i+:2] == 2'b11) c[2*i+:2] = 2'b00;
		end
		return c;
	endfunction : exp_gates
	// Compares one result and counts it.
	task chk(input string name, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, e, s);
		end
	endtask : chk
	// Prints the verdict and ends the run.
	task results;
		if (n_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	// Waits a bounded time for a mode; running out ends the run.
	task wait_mode(input logic [1:0] m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++) @(negedge clk);
		chk("mode", {6'h00, m}, {6'h00, mode});
		if (mode !== m) results();
	endtask : wait_mode
	// Waits a number of falling edges.
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Main sequence.
	initial begin
		srst      = 1'b1;
		tr1       = 1'b1;
		tr2       = 1'b1;
		sleep_sel = 1'b0;
		pu_en     = 1'b0;
		bus_cfg   = 1'b0;
		fault_in  = 1'b0;
		dt_cfg    = 4'h0;
		void'($urandom(32'h3e83));
		cyc(10);
		srst = 1'b0;
		u_essc_host_model.drive_en(1'b1);
		for (int k = 0; k < 40; k++) begin
			u_essc_host_model.set_cmd(k == 0 ? 6'h3f : 6'($urandom));
			tr1 = 1'($urandom);
			tr2 = 1'($urandom);
			cyc(3);
			chk("gates", {2'h0, exp_gates(cmd)}, {2'h0, g});
			chk("translators", {6'h00, ~tr1, ~tr2}, {6'h00, tr1_oe, tr2_oe});
		end
		u_essc_host_model.set_cmd(6'h2a);
		cyc(3);
		u_essc_host_model.drive_en(1'b0);
		cyc(1);
		chk("gates off", 8'h00, {2'h0, g});
		v = 1'($urandom);
		pu_en = v;
		cyc(8);
		u_essc_host_model.drive_en(1'b1);
		pu_en = ~v;
		cyc(6);
		chk("pullup", {7'h00, v}, {7'h00, pu_on});
		chk("mode short", 8'h00, {6'h00, mode});
		fault_in = 1'b1;
		cyc(1);
		fault_in = 1'b0;
		cyc(2);
		chk("fault set", 8'h03, {6'h00, flt, flt_oe});
		fault_in = 1'b1;
		u_essc_host_model.low_pulse(5);
		cyc(6);
		fault_in = 1'b0;
		cyc(2);
		chk("fault kept", 8'h03, {6'h00, flt, flt_oe});
		u_essc_host_model.low_pulse(5);
		cyc(6);
		chk("fault clear", 8'h00, {6'h00, flt, flt_oe});
		bus_cfg = 1'($urandom);
		u_essc_host_model.drive_en(1'b0);
		wait_mode(2'h1, 40);
		cyc(2);
		chk("standby", {4'h0, 3'h0, bus_cfg}, {4'h0, amp, r12, r5, bus_pu});
		u_essc_host_model.drive_en(1'b1);
		wait_mode(2'h0, 10);
		cyc(2);
		chk("normal", 8'h0f, {4'h0, amp, r12, r5, bus_pu});
		dt_cfg = 4'($urandom_range(15, 1));
		u_essc_host_model.set_cmd(6'h10);
		cyc(int'(dt_cfg));
		chk("dead gap", 8'h00, {2'h0, g});
		cyc(1);
		chk("dead end", 8'h10, {2'h0, g});
		sleep_sel = 1'b1;
		u_essc_host_model.drive_en(1'b0);
		wait_mode(2'h2, 40);
		cyc(2);
		chk("sleep pullup", 8'h00, {7'h00, bus_pu});
		u_essc_host_model.drive_en(1'b1);
		cyc(20);
		chk("no wake", 8'h02, {6'h00, mode});
		u_essc_host_model.low_pulse(2600);
		wait_mode(2'h0, 10);
		u_essc_host_model.drive_en(1'b0);
		wait_mode(2'h2, 40);
		tr1 = 1'b0;
		cyc(2600);
		tr1 = 1'b1;
		wait_mode(2'h1, 10);
		chk("variant sleep", 8'h02, {6'h00, mode_b});
		u_essc_host_model.bus_pulse(1000);
		cyc(6);
		chk("bus short", 8'h02, {6'h00, mode_b});
		u_essc_host_model.bus_pulse(2600);
		cyc(6);
		chk("bus wake", 8'h01, {6'h00, mode_b});
		chk("variant reg5", 8'h01, {7'h00, r5_b});
		results();
	end
endmodule : tb_top
bind essc_ctrl essc_assertions #(.DEADTIME_W(DEADTIME_W)) u_essc_assertions (.clk, .srst,
	.chip_enable, .deadtime_config_reg,
	.driver_fault_active, .phase_a_high_cmd, .phase_a_high_gate, .phase_a_low_gate,
	.phase_b_high_gate, .phase_b_low_gate, .phase_c_high_gate, .phase_c_low_gate,
	.translator_one_input, .translator_one_output_oe, .current_limit_fault_output_oe,
	.input_pullup_on, .amp_enable, .reg12_enable, .bus_pullup_on, .fault_latched, .mode);
